// *** hdl/gpc_pin_config_low.sv ***
// configuration register and pad control for pins 0 to 7
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_config_low (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [gpc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [1:0] reg_size_i,
  input wire logic [gpc_pkg::REG_W-1:0] reg_wdata_i,
  output logic [gpc_pkg::REG_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [gpc_pkg::NUM_PINS-1:0] lock_i,
  input wire logic [gpc_pkg::NUM_PINS-1:0] out_data_i,
  input wire logic [gpc_pkg::NUM_PINS-1:0] af_out_i,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pad_in_i,
  input wire logic tamper_en_i,
  input wire logic clk_out_en_i,
  input wire logic clk_out_i,
  output logic [gpc_pkg::NUM_PINS-1:0] pad_out_o,
  output logic [gpc_pkg::NUM_PINS-1:0] pad_oe_n_o,
  output logic [gpc_pkg::NUM_PINS-1:0] pull_en_o,
  output logic [gpc_pkg::NUM_PINS-1:0] pull_up_o,
  output logic [gpc_pkg::NUM_PINS-1:0] schmitt_en_o,
  output logic [2*gpc_pkg::NUM_PINS-1:0] speed_o,
  output logic [gpc_pkg::NUM_PINS-1:0] in_data_o,
  output logic tamper_in_o
);
  import gpc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0] cfg_reg;
  logic [REG_W-1:0] cfg_next;
  logic [REG_W-1:0] rdata_reg;
  logic [REG_W-1:0] rdata_next;
  logic rvalid_reg;
  logic sel;
  logic word_ok;
  logic wr_hit;
  logic rd_hit;
  logic [NUM_PINS-1:0] drv_next;
  logic [NUM_PINS-1:0] oen_next;
  logic [NUM_PINS-1:0] pen_next;
  logic [NUM_PINS-1:0] pup_next;
  logic [NUM_PINS-1:0] smt_next;
  logic [NUM_PINS-1:0] in_next;
  logic [2*NUM_PINS-1:0] spd_next;
  logic [NUM_PINS-1:0] drv_reg;
  logic [NUM_PINS-1:0] oen_reg;
  logic [NUM_PINS-1:0] pen_reg;
  logic [NUM_PINS-1:0] pup_reg;
  logic [NUM_PINS-1:0] smt_reg;
  logic [NUM_PINS-1:0] in_reg;
  logic [2*NUM_PINS-1:0] spd_reg;
  logic tamper_reg;
  logic tamper_next;

  gpc_pin_if pin ();

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  assign sel = (reg_addr_i == CFG_OFFSET);
  assign word_ok = (reg_size_i == SIZE_WORD);
  assign wr_hit = reg_wr_i && sel && word_ok;
  assign rd_hit = reg_rd_i && sel && word_ok;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_hit) begin
      for (int y = 0; y < NUM_PINS; y++) begin
        if (!lock_i[y]) begin
          cfg_next[FIELD_W*y +: FIELD_W] = reg_wdata_i[FIELD_W*y +: FIELD_W];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read back unchanged
  assign rdata_next = rd_hit ? cfg_reg : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_i;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

  // ----------------------------------------------------------------
  // pad decode
  // ----------------------------------------------------------------
  assign pin.cfg = cfg_reg;
  assign pin.out_data = out_data_i;
  assign pin.af_data = af_out_i;
  assign pin.pad_in = pad_in_i;

  gpc_pin_decode u_decode (
    .pin (pin.dec)
  );

  // ----------------------------------------------------------------
  // speed class and shared pin override
  // ----------------------------------------------------------------
  always_comb begin
    drv_next = pin.drive;
    oen_next = pin.oe_n;
    pen_next = pin.pull_en;
    pup_next = pin.pull_up;
    smt_next = pin.schmitt_en;
    in_next = pin.in_val;
    spd_next = '0;
    tamper_next = 1'b0;
    for (int y = 0; y < NUM_PINS; y++) begin
      spd_next[2*y +: 2] = pin_mode(cfg_reg, y);
    end
    if (clk_out_en_i) begin
      drv_next[TAMPER_PIN] = clk_out_i;
      oen_next[TAMPER_PIN] = 1'b0;
      pen_next[TAMPER_PIN] = 1'b0;
      pup_next[TAMPER_PIN] = 1'b0;
      smt_next[TAMPER_PIN] = 1'b1;
      in_next[TAMPER_PIN] = pad_in_i[TAMPER_PIN];
      spd_next[2*TAMPER_PIN +: 2] = MODE_OUT_50MHZ;
    end else if (tamper_en_i) begin
      drv_next[TAMPER_PIN] = 1'b0;
      oen_next[TAMPER_PIN] = 1'b1;
      pen_next[TAMPER_PIN] = 1'b0;
      pup_next[TAMPER_PIN] = 1'b0;
      smt_next[TAMPER_PIN] = 1'b1;
      in_next[TAMPER_PIN] = pad_in_i[TAMPER_PIN];
      spd_next[2*TAMPER_PIN +: 2] = MODE_INPUT;
      tamper_next = pad_in_i[TAMPER_PIN];
    end
  end

  // ----------------------------------------------------------------
  // pad outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_reg <= '0;
      oen_reg <= '1;
    end else begin
      drv_reg <= drv_next;
      oen_reg <= oen_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pen_reg <= '0;
      pup_reg <= '0;
      smt_reg <= '1;
    end else begin
      pen_reg <= pen_next;
      pup_reg <= pup_next;
      smt_reg <= smt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spd_reg <= '0;
    end else begin
      spd_reg <= spd_next;
    end
  end

  // ----------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_reg <= '0;
      tamper_reg <= 1'b0;
    end else begin
      in_reg <= in_next;
      tamper_reg <= tamper_next;
    end
  end

  assign pad_out_o = drv_reg;
  assign pad_oe_n_o = oen_reg;
  assign pull_en_o = pen_reg;
  assign pull_up_o = pup_reg;
  assign schmitt_en_o = smt_reg;
  assign speed_o = spd_reg;
  assign in_data_o = in_reg;
  assign tamper_in_o = tamper_reg;

endmodule // gpc_pin_config_low
`default_nettype wire

// *** shared/gpc_pkg.sv ***
// constants and helpers for the pin configuration block
package gpc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 8;
  localparam int FIELD_W = 4;
  localparam int REG_W = 32;
  localparam int ADDR_W = 8;
  localparam int MODE_LSB = 0;
  localparam int TYPE_LSB = 2;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h00;
  localparam logic [REG_W-1:0] CFG_RESET = 32'h44444444;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ----------------------------------------------------------------
  // direction and speed codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_OUT_10MHZ = 2'h1;
  localparam logic [1:0] MODE_OUT_2MHZ = 2'h2;
  localparam logic [1:0] MODE_OUT_50MHZ = 2'h3;

  // ----------------------------------------------------------------
  // pin type codes, input mode
  // ----------------------------------------------------------------
  localparam logic [1:0] TYPE_ANALOG = 2'h0;
  localparam logic [1:0] TYPE_FLOAT = 2'h1;
  localparam logic [1:0] TYPE_PULL = 2'h2;
  localparam logic [1:0] TYPE_IN_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // pin type codes, output mode
  // ----------------------------------------------------------------
  localparam logic [1:0] TYPE_GP_PP = 2'h0;
  localparam logic [1:0] TYPE_GP_OD = 2'h1;
  localparam logic [1:0] TYPE_AF_PP = 2'h2;
  localparam logic [1:0] TYPE_AF_OD = 2'h3;

  // ----------------------------------------------------------------
  // pin shared with tamper input and clock output
  // ----------------------------------------------------------------
  localparam int TAMPER_PIN = 3;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] pin_mode(input logic [REG_W-1:0] cfg,
                                          input int y);
    pin_mode = cfg[FIELD_W*y+MODE_LSB +: 2];
  endfunction

  function automatic logic [1:0] pin_type(input logic [REG_W-1:0] cfg,
                                          input int y);
    pin_type = cfg[FIELD_W*y+TYPE_LSB +: 2];
  endfunction

endpackage

// *** shared/gpc_pin_if.sv ***
// carrier between register logic and per-pin pad decoder
`timescale 1ns/100ps
`default_nettype none
interface gpc_pin_if;
  import gpc_pkg::*;
  logic [REG_W-1:0] cfg;
  logic [NUM_PINS-1:0] out_data;
  logic [NUM_PINS-1:0] af_data;
  logic [NUM_PINS-1:0] pad_in;
  logic [NUM_PINS-1:0] drive;
  logic [NUM_PINS-1:0] oe_n;
  logic [NUM_PINS-1:0] pull_en;
  logic [NUM_PINS-1:0] pull_up;
  logic [NUM_PINS-1:0] schmitt_en;
  logic [NUM_PINS-1:0] in_val;

  modport ctrl (
    output cfg, out_data, af_data, pad_in,
    input drive, oe_n, pull_en, pull_up, schmitt_en, in_val
  );
  modport dec (
    input cfg, out_data, af_data, pad_in,
    output drive, oe_n, pull_en, pull_up, schmitt_en, in_val
  );
endinterface
`default_nettype wire

// *** hdl/gpc_pin_decode.sv ***
// per-pin pad control decode from configuration fields
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_decode (
  gpc_pin_if.dec pin
);
  import gpc_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] m;
    logic [1:0] t;
    logic d;
    m = 2'h0;
    t = 2'h0;
    d = 1'b0;
    pin.drive = '0;
    pin.oe_n = '1;
    pin.pull_en = '0;
    pin.pull_up = '0;
    pin.schmitt_en = '1;
    pin.in_val = '0;
    for (int y = 0; y < NUM_PINS; y++) begin
      m = pin_mode(pin.cfg, y);
      t = pin_type(pin.cfg, y);
      pin.in_val[y] = pin.pad_in[y];
      if (m == MODE_INPUT) begin
        unique case (t)
          TYPE_ANALOG: begin
            pin.schmitt_en[y] = 1'b0;
            pin.in_val[y] = 1'b0;
          end
          TYPE_FLOAT: begin
          end
          TYPE_PULL: begin
            pin.pull_en[y] = 1'b1;
            pin.pull_up[y] = pin.out_data[y];
          end
          TYPE_IN_RSVD: begin
          end
        endcase
      end else begin
        d = t[1] ? pin.af_data[y] : pin.out_data[y];
        unique case (t)
          TYPE_GP_PP, TYPE_AF_PP: begin
            pin.drive[y] = d;
            pin.oe_n[y] = 1'b0;
          end
          TYPE_GP_OD, TYPE_AF_OD: begin
            pin.drive[y] = 1'b0;
            pin.oe_n[y] = d;
          end
        endcase
      end
    end
  end

endmodule // gpc_pin_decode
`default_nettype wire

// *** sim/gpc_pin_config_low_monitor.sv ***
// port assertions for the pin configuration block
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_config_low_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [1:0] reg_size_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [7:0] out_data_i,
  input wire logic clk_out_en_i,
  input wire logic [7:0] pad_oe_n_o,
  input wire logic [7:0] pull_en_o,
  input wire logic [7:0] pull_up_o,
  input wire logic [7:0] schmitt_en_o,
  input wire logic [15:0] speed_o,
  input wire logic [7:0] in_data_o
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_lat; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late read");
  property p_rd_idle;
    !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read");
  property p_refuse;
    reg_rd_i && (reg_addr_i != 8'h0 || reg_size_i != 2'h2)
      |=> reg_rdata_o == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad read");
  property p_reset; disable iff (1'b0)
    rst_i |=> pad_oe_n_o == 8'hff && speed_o == 16'h0 && pull_en_o == 8'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset pads");
  property p_in0; speed_o[1:0] == 2'h0 |-> pad_oe_n_o[0]; endproperty
  a_in0: assert property (p_in0) else $error("input drives");
  property p_out0;
    speed_o[1:0] != 2'h0 |-> !pull_en_o[0] && schmitt_en_o[0];
  endproperty
  a_out0: assert property (p_out0) else $error("output pulls");
  property p_analog;
    (~schmitt_en_o & (in_data_o | pull_en_o | ~pad_oe_n_o)) == 8'h0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin");
  property p_pull;
    ((pull_up_o ^ $past(out_data_i)) & pull_en_o) == 8'h0;
  endproperty
  a_pull: assert property (p_pull) else $error("pull dir");
  property p_clkout;
    clk_out_en_i |=> !pad_oe_n_o[3] && speed_o[7:6] == 2'h3;
  endproperty
  a_clkout: assert property (p_clkout) else $error("clk pin");
endmodule // gpc_pin_config_low_monitor
bind gpc_pin_config_low gpc_pin_config_low_monitor i_mon (.clk_i, .rst_i,
  .reg_rd_i, .reg_addr_i, .reg_size_i, .reg_rdata_o, .reg_rvalid_o,
  .out_data_i, .clk_out_en_i, .pad_oe_n_o, .pull_en_o, .pull_up_o,
  .schmitt_en_o, .speed_o, .in_data_o);
`default_nettype wire

// *** sim/gpc_pad_model.sv ***
// pad wires and outside drivers for the eight pins
`timescale 1ns/100ps
`default_nettype none
module gpc_pad_model (
  input wire logic clk_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pull_en_i,
  input wire logic [7:0] pull_up_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] lvl_o
);
  logic [7:0] drift_reg = 8'h5a;
  // ----
  // wire level
  // ----
  always_ff @(posedge clk_i) begin
    drift_reg <= ~drift_reg;
  end
  assign lvl_o = ~oe_n_i & drv_i | oe_n_i & (ext_en_i & ext_i |
    ~ext_en_i & (pull_en_i & pull_up_i | ~pull_en_i & drift_reg));
endmodule // gpc_pad_model
`default_nettype wire

// *** sim/gpc_pin_config_low_tb.sv ***
// self-checking bench for the pin configuration block
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_config_low_tb;
  import gpc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic tamper_en_i = 1'b0, clk_out_en_i = 1'b0, clk_out_i = 1'b0;
  logic reg_rvalid_o, tamper_in_o;
  logic [1:0] reg_size_i = 2'h2;
  logic [7:0] reg_addr_i = 8'h0, lock_i = 8'h0, out_data_i = 8'h0;
  logic [7:0] af_out_i = 8'h0, ext = 8'h3c, ext_en = 8'hff, pad_in_i;
  logic [7:0] pad_out_o, pad_oe_n_o, pull_en_o, pull_up_o, schmitt_en_o;
  logic [7:0] in_data_o;
  logic [15:0] speed_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, cfg = CFG_RESET;
  logic [31:0] exp_q[$];
  int n_mismatch = 0, check_count = 0, cyc = 0, seed = 63;
  gpc_pin_config_low i_dut (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_size_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .lock_i, .out_data_i, .af_out_i, .pad_in_i, .tamper_en_i,
    .clk_out_en_i, .clk_out_i, .pad_out_o, .pad_oe_n_o, .pull_en_o,
    .pull_up_o, .schmitt_en_o, .speed_o, .in_data_o, .tamper_in_o);
  gpc_pad_model i_pad (.clk_i, .drv_i(pad_out_o), .oe_n_i(pad_oe_n_o),
    .pull_en_i(pull_en_o), .pull_up_i(pull_up_o), .ext_en_i(ext_en),
    .ext_i(ext), .lvl_o(pad_in_i));
  // ----
  // helpers
  // ----
  initial forever #2.5 clk_i = ~clk_i;
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, rd, input logic [7:0] a,
                     input logic [1:0] sz, input logic [31:0] d);
    logic [31:0] m;
    for (int y = 0; y < 8; y++) m[4*y +: 4] = {4{lock_i[y]}};
    @(negedge clk_i);
    reg_wr_i = wr;
    reg_rd_i = rd;
    reg_addr_i = a;
    reg_size_i = sz;
    reg_wdata_i = d;
    if (rd) exp_q.push_back(a == CFG_OFFSET && sz == SIZE_WORD ? cfg : 0);
    if (wr && a == CFG_OFFSET && sz == SIZE_WORD) cfg = cfg & m | d & ~m;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
  endtask
  task automatic pads;
    logic [7:0] eoe, epu, eout, ein;
    logic [15:0] esp;
    logic [3:0] f;
    logic dv;
    repeat (3) @(negedge clk_i);
    for (int y = 0; y < 8; y++) begin
      f = cfg[4*y +: 4];
      dv = f[3] ? af_out_i[y] : out_data_i[y];
      esp[2*y +: 2] = f[1:0];
      eoe[y] = f[1:0] == MODE_INPUT | f[2] & dv;
      epu[y] = f == 4'h8;
      eout[y] = ~f[2] & dv;
      ein[y] = f != 4'h0 & pad_in_i[y];
    end
    chk(32'(speed_o), 32'(esp));
    chk(32'(pad_oe_n_o), 32'(eoe));
    chk(32'(pad_out_o & ~eoe), 32'(eout & ~eoe));
    chk(32'(pull_en_o), 32'(epu));
    chk(32'(in_data_o), 32'(ein));
  endtask
  always @(negedge clk_i) begin
    if (reg_rvalid_o === 1'b1) chk(reg_rdata_o, exp_q.pop_front());
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test;
    end
  end
  // ----
  // stimulus
  // ----
  initial begin
    logic [31:0] w;
    logic [31:0] g;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    acc(1'b0, 1'b1, CFG_OFFSET, SIZE_WORD, 32'h0);
    pads;
    for (int i = 0; i < 6; i++) begin
      out_data_i = 8'($random(seed));
      af_out_i = 8'($random(seed));
      ext = 8'($random(seed));
      w = i == 0 ? 32'h76543210 : 32'hfedcba98;
      if (i > 1) w = $random(seed);
      acc(1'b1, 1'b0, CFG_OFFSET, SIZE_WORD, w);
      acc(1'b0, 1'b1, CFG_OFFSET, SIZE_WORD, 32'h0);
      pads;
    end
    for (int s = 0; s < 4; s++) acc(1'b1, 1'b1, 8'h0, 2'(s), ~cfg);
    acc(1'b1, 1'b1, 8'h04, SIZE_WORD, 32'h0);
    acc(1'b0, 1'b1, CFG_OFFSET, SIZE_WORD, 32'h0);
    lock_i = 8'($random(seed));
    acc(1'b1, 1'b0, CFG_OFFSET, SIZE_WORD, $random(seed));
    acc(1'b0, 1'b1, CFG_OFFSET, SIZE_WORD, 32'h0);
    lock_i = 8'h0;
    tamper_en_i = 1'b1;
    repeat (2) @(negedge clk_i);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) clk_out_en_i = 1'b1;
      ext[3] = ~ext[3];
      clk_out_i = ~clk_out_i;
      w = k < 4 ? {28'h0, 1'b1, MODE_INPUT, ext[3]}
                : {28'h0, 1'b0, MODE_OUT_50MHZ, clk_out_i};
      @(negedge clk_i);
      g = {28'h0, pad_oe_n_o[3], speed_o[7:6], pad_out_o[3]};
      if (k < 4) g[0] = tamper_in_o;
      chk(g, w);
    end
    tamper_en_i = 1'b0;
    clk_out_en_i = 1'b0;
    acc(1'b0, 1'b1, CFG_OFFSET, SIZE_WORD, 32'h0);
    repeat (2) @(negedge clk_i);
    finish_test;
  end
endmodule // gpc_pin_config_low_tb
`default_nettype wire
